// File: rtl/sac_pkg.sv
/*
 * Constants, field positions and carrier types for the system and
 * auxiliary control register bank.
 * Assumes a pipeline that presents one coprocessor move per request.
 */
package sac_pkg;

    // ==========================================================
    // Decode of the two control registers
    localparam logic [3:0] SAC_SYS_COPROC = 4'hf;
    localparam logic [2:0] SAC_OPC1_CTRL = 3'h0;
    localparam logic [3:0] SAC_CRN_CTRL = 4'h1;
    localparam logic [3:0] SAC_CRM_CTRL = 4'h0;
    localparam logic [2:0] SAC_OPC2_SYS = 3'h0;
    localparam logic [2:0] SAC_OPC2_AUX = 3'h1;

    // ==========================================================
    // Field positions of system_control
    localparam int SYS_MMU_BIT = 0;
    localparam int SYS_ALIGN_BIT = 1;
    localparam int SYS_DCACHE_BIT = 2;
    localparam int SYS_HIVEC_BIT = 13;
    localparam int SYS_RR_BIT = 14;

    // ==========================================================
    // Field positions of auxiliary_control
    localparam int AUX_BCAST_BIT = 0;
    localparam int AUX_L2PF_BIT = 1;
    localparam int AUX_L1PF_BIT = 2;
    localparam int AUX_ZERO_BIT = 3;
    localparam int AUX_COH_BIT = 6;
    localparam int AUX_EXCLUSIVE_BIT = 7;
    localparam int AUX_ONEWAY_BIT = 8;
    localparam int AUX_PARITY_BIT = 9;
    localparam logic [31:0] AUX_WMASK = 32'h0000_03cf;

    // ==========================================================
    // Reset values and vector bases
    localparam logic [31:0] AUX_RST = 32'h0000_0000;
    localparam logic SYS_FIELD_RST = 1'b0;
    localparam logic [31:0] LOW_VEC_BASE = 32'h0000_0000;
    localparam logic [31:0] HIGH_VEC_BASE = 32'hffff_0000;

    // ==========================================================
    // Carrier types
    typedef struct packed {
        logic write;
        logic [3:0] coproc;
        logic [2:0] opc1;
        logic [3:0] crn;
        logic [3:0] crm;
        logic [2:0] opc2;
        logic [31:0] wdata;
    } sac_cp_req_type;

    typedef struct packed {
        logic privileged;
        logic nonsecure;
    } sac_cpu_state_type;

    typedef struct packed {
        logic high_vec;
        logic dcache_en;
        logic align_chk;
        logic mmu_en;
    } sac_sys_bank_type;

    // Strap capture after reset release, Gray along the path
    typedef enum logic [1:0] {
        STRAP_SYNC1 = 2'b00,
        STRAP_SYNC2 = 2'b01,
        STRAP_TAKE = 2'b11,
        STRAP_DONE = 2'b10
    } sac_strap_type;

endpackage : sac_pkg

// File: rtl/sac_sync2.sv
/*
 * Two-flop synchroniser for a vector of independent levels.
 * Assumes each bit is a slow level, not a multi-bit word.
 */
`timescale 1ns/1ps
`default_nettype none
module sac_sync2 #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Levels
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    // First stage is read only by the second
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= i_async;
            sync_ff <= meta_ff;
        end
    end

    assign o_sync = sync_ff;
endmodule : sac_sync2
`default_nettype wire

// File: rtl/sac_ctrl_regs.sv
/*
 * System and auxiliary control registers reached by coprocessor
 * moves, with banked security copies and the derived control lines.
 * Assumes the pipeline holds mode and security state stable with each
 * request and waits for o_cp_done before the next one.
 */
`timescale 1ns/1ps
`default_nettype none

module sac_ctrl_regs
    import sac_pkg::*;
#(
    parameter int NUM_CORES = 1,
    parameter bit PARITY_IMPL = 1'b1
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Coprocessor move request from the pipeline
    input wire logic i_cp_valid,
    input wire sac_pkg::sac_cp_req_type i_cp_req,
    input wire sac_pkg::sac_cpu_state_type i_cpu,
    input wire logic i_nonsecure_coherency_permit,
    // Pins
    input wire logic i_secure_coproc_write_block,
    input wire logic i_high_vector_reset_input,
    // Answer
    output logic o_cp_done,
    output logic o_cp_claim,
    output logic o_cp_undef,
    output logic [31:0] o_cp_rdata,
    // Control seen by the core
    output sac_pkg::sac_sys_bank_type o_sys_view,
    output logic o_rr_replace,
    output logic [31:0] o_vector_base,
    output logic [31:0] o_aux_ctrl,
    output logic o_inner_shared_cacheable,
    output logic o_bcast_send_en,
    output logic o_bcast_recv_en,
    output logic o_coherent_req_en
);
    import sac_pkg::*;

    // ==========================================================
    // Pin synchronisers
    logic block_sync;
    logic hivec_sync;
    logic [1:0] pins_sync;

    sac_sync2 #(
        .W(2)
    ) u_sync (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_async({i_secure_coproc_write_block,
                  i_high_vector_reset_input}),
        .o_sync(pins_sync)
    );

    assign block_sync = pins_sync[1];
    assign hivec_sync = pins_sync[0];

    // ==========================================================
    // Strap capture of the secure vectors bit
    // Caught by clock after release, never by the async reset
    sac_strap_type strap_ff;
    sac_strap_type nxt_strap;

    always_comb begin
        case (strap_ff)
            STRAP_SYNC1: nxt_strap = STRAP_SYNC2;
            STRAP_SYNC2: nxt_strap = STRAP_TAKE;
            STRAP_TAKE: nxt_strap = STRAP_DONE;
            STRAP_DONE: nxt_strap = STRAP_DONE;
            default: nxt_strap = STRAP_SYNC1;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            strap_ff <= STRAP_SYNC1;
        end else begin
            strap_ff <= nxt_strap;
        end
    end

    // ==========================================================
    // Decode
    logic is_ctrl;
    logic hit_sys;
    logic hit_aux;
    logic hit;
    logic undef_user;
    logic undef_block;
    logic undef;
    logic wr_ok;
    logic rd_ok;
    logic ns;

    assign ns = i_cpu.nonsecure;
    assign is_ctrl = i_cp_valid
        && (i_cp_req.coproc == SAC_SYS_COPROC)
        && (i_cp_req.opc1 == SAC_OPC1_CTRL)
        && (i_cp_req.crn == SAC_CRN_CTRL)
        && (i_cp_req.crm == SAC_CRM_CTRL);
    assign hit_sys = is_ctrl && (i_cp_req.opc2 == SAC_OPC2_SYS);
    assign hit_aux = is_ctrl && (i_cp_req.opc2 == SAC_OPC2_AUX);
    assign hit = hit_sys || hit_aux;
    // Both registers refuse User mode
    assign undef_user = hit && !i_cpu.privileged;
    assign undef_block = hit && i_cp_req.write && i_cpu.privileged
        && !ns && block_sync;
    assign undef = undef_user || undef_block;
    assign wr_ok = hit && i_cp_req.write && !undef;
    assign rd_ok = hit && !i_cp_req.write && !undef;

    // ==========================================================
    // System control: banked copies and secure-only field
    sac_sys_bank_type sys_s_ff;
    sac_sys_bank_type sys_ns_ff;
    sac_sys_bank_type wr_bank;
    sac_sys_bank_type cur_bank;
    logic rr_ff;

    // Only the implemented fields are taken; the rest are read-only
    assign wr_bank.high_vec = i_cp_req.wdata[SYS_HIVEC_BIT];
    assign wr_bank.dcache_en = i_cp_req.wdata[SYS_DCACHE_BIT];
    assign wr_bank.align_chk = i_cp_req.wdata[SYS_ALIGN_BIT];
    assign wr_bank.mmu_en = i_cp_req.wdata[SYS_MMU_BIT];
    assign cur_bank = ns ? sys_ns_ff : sys_s_ff;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sys_s_ff <= '{default: SYS_FIELD_RST};
        end else if (strap_ff == STRAP_TAKE) begin
            sys_s_ff.high_vec <= hivec_sync;
        end else if (wr_ok && hit_sys && !ns) begin
            sys_s_ff <= wr_bank;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sys_ns_ff <= '{default: SYS_FIELD_RST};
        end else if (wr_ok && hit_sys && ns) begin
            sys_ns_ff <= wr_bank;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rr_ff <= SYS_FIELD_RST;
        end else if (wr_ok && hit_sys && !ns) begin
            rr_ff <= i_cp_req.wdata[SYS_RR_BIT];
        end
    end

    // ==========================================================
    // Auxiliary control: one shared copy
    logic [31:0] aux_ff;
    logic [31:0] aux_wmask;

    // Absent features read zero and ignore writes
    always_comb begin
        aux_wmask = AUX_WMASK;
        if (!PARITY_IMPL) begin
            aux_wmask[AUX_PARITY_BIT] = 1'b0;
        end
        if (NUM_CORES == 1) begin
            aux_wmask[AUX_BCAST_BIT] = 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            aux_ff <= AUX_RST;
        end else if (wr_ok && hit_aux) begin
            if (!ns) begin
                aux_ff <= i_cp_req.wdata & aux_wmask;
            end else if (i_nonsecure_coherency_permit) begin
                aux_ff[AUX_COH_BIT] <= i_cp_req.wdata[AUX_COH_BIT];
            end
        end
    end

    // ==========================================================
    // Read data
    logic [31:0] rd_sys;

    always_comb begin
        rd_sys = '0;
        rd_sys[SYS_MMU_BIT] = cur_bank.mmu_en;
        rd_sys[SYS_ALIGN_BIT] = cur_bank.align_chk;
        rd_sys[SYS_DCACHE_BIT] = cur_bank.dcache_en;
        rd_sys[SYS_HIVEC_BIT] = cur_bank.high_vec;
        rd_sys[SYS_RR_BIT] = rr_ff;
    end

    // ==========================================================
    // Answer, one cycle after the request
    logic done_ff;
    logic claim_ff;
    logic undef_ff;
    logic [31:0] rdata_ff;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            done_ff <= 1'b0;
            claim_ff <= 1'b0;
            undef_ff <= 1'b0;
        end else begin
            done_ff <= i_cp_valid;
            claim_ff <= hit;
            undef_ff <= undef;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rdata_ff <= '0;
        end else if (rd_ok) begin
            rdata_ff <= hit_sys ? rd_sys : aux_ff;
        end else if (i_cp_valid) begin
            rdata_ff <= '0;
        end
    end

    assign o_cp_done = done_ff;
    assign o_cp_claim = claim_ff;
    assign o_cp_undef = undef_ff;
    assign o_cp_rdata = rdata_ff;

    // ==========================================================
    // Control lines to the core
    logic multi;
    logic coh;
    // Mux of registers: follows the security state with no lag
    assign multi = (NUM_CORES > 1);
    assign coh = aux_ff[AUX_COH_BIT];
    assign o_sys_view = cur_bank;
    assign o_rr_replace = rr_ff;
    assign o_vector_base = cur_bank.high_vec ? HIGH_VEC_BASE
                                             : LOW_VEC_BASE;
    assign o_aux_ctrl = aux_ff;
    assign o_inner_shared_cacheable = coh;
    assign o_bcast_send_en = multi && coh && aux_ff[AUX_BCAST_BIT];
    assign o_bcast_recv_en = multi && coh && aux_ff[AUX_BCAST_BIT];
    assign o_coherent_req_en = multi && coh;

    // ==========================================================
    // Checks
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_b);

    sequence s_user_req;
        i_cp_valid && hit && !i_cpu.privileged;
    endsequence

    // Back-to-back moves are legal, so no falling step is demanded
    sequence s_undef_ans;
        o_cp_done && o_cp_claim && o_cp_undef && (o_cp_rdata == '0);
    endsequence

    a_user_undef: assert property (
        s_user_req |=> s_undef_ans)
        else $error("user access not refused");

    a_block_write: assert property (
        i_cp_valid && hit && i_cp_req.write && i_cpu.privileged && !ns
        && block_sync |=> o_cp_undef && $stable(sys_s_ff)
        && $stable(aux_ff))
        else $error("blocked write took effect");

    a_ns_rr_keep: assert property (
        i_cp_valid && hit_sys && ns |=> $stable(rr_ff))
        else $error("secure-only field changed from non-secure");

    a_rr_readback: assert property (
        rd_ok && hit_sys |=> o_cp_rdata[SYS_RR_BIT] == $past(rr_ff))
        else $error("secure-only field read wrong copy");

    a_ro_zero: assert property (
        o_cp_done && $past(hit_sys) |-> o_cp_rdata[31:15] == '0
        && o_cp_rdata[12:3] == '0)
        else $error("read-only system bits not zero");

    a_aux_ns_ro: assert property (
        wr_ok && hit_aux && ns && !i_nonsecure_coherency_permit
        |=> $stable(aux_ff))
        else $error("non-secure write changed auxiliary");

    a_aux_ns_coh: assert property (
        wr_ok && hit_aux && ns && i_nonsecure_coherency_permit
        |=> aux_ff == ({$past(aux_ff)} & ~(32'h1 << AUX_COH_BIT)
        | ({31'h0, $past(i_cp_req.wdata[AUX_COH_BIT])} << AUX_COH_BIT)))
        else $error("non-secure write touched other fields");

    a_bcast_gate: assert property (
        o_bcast_send_en |-> multi && aux_ff[AUX_COH_BIT]
        && aux_ff[AUX_BCAST_BIT])
        else $error("broadcast enabled without gating bits");

    a_reserved_aux: assert property (
        (aux_ff & ~aux_wmask) == '0)
        else $error("reserved auxiliary bit set");

    a_vec_base: assert property (
        strap_ff == STRAP_TAKE && !ns |=> o_vector_base ==
        ($past(hivec_sync) ? HIGH_VEC_BASE : LOW_VEC_BASE))
        else $error("vector base not taken from strap");

    a_sys_write: assert property (
        wr_ok && hit_sys && ns |=> o_sys_view.dcache_en ==
        $past(i_cp_req.wdata[SYS_DCACHE_BIT]) || !ns)
        else $error("banked system write lost");
endmodule : sac_ctrl_regs
`default_nettype wire

// File: sim/sac_pipe_model.sv
/*
 * Pipeline model that issues one coprocessor move at a time.
 * Assumes the register bank answers exactly one cycle after a request.
 */
`timescale 1ns/1ps
`default_nettype none
module sac_pipe_model #(
    parameter bit SLV_OPT = 1'b1
) (
    // Clock
    input wire logic i_clk,
    // Request
    output sac_pkg::sac_cp_req_type o_req,
    output logic o_valid,
    output sac_pkg::sac_cpu_state_type o_cpu,
    // Answer
    input wire logic i_done,
    input wire logic i_claim,
    input wire logic i_undef,
    input wire logic [31:0] i_rdata
);
    import sac_pkg::*;

    localparam logic [17:0] AUX_A = {SAC_SYS_COPROC, SAC_OPC1_CTRL,
        SAC_CRN_CTRL, SAC_CRM_CTRL, SAC_OPC2_AUX};

    initial begin
        o_valid = 1'b0;
        o_req = '0;
        o_cpu = '0;
    end

    // ==========================================================
    // Mode level, held between moves
    task automatic set_state(input logic priv, input logic ns);
        @(posedge i_clk);
        o_cpu <= {priv, ns};
    endtask : set_state

    // ==========================================================
    // One move; answer is {done, claim, undef, rdata}
    task automatic move(input logic wr, input logic [17:0] addr,
            input logic [31:0] wd, output logic [34:0] ans);
        @(posedge i_clk);
        o_valid <= 1'b1;
        o_req <= {wr, addr, wd};
        @(posedge i_clk);
        o_valid <= 1'b0;
        #1;
        ans = {i_done, i_claim, i_undef, i_rdata};
    endtask : move

    // ==========================================================
    // Read, merge, write back so untouched fields survive
    task automatic rmw_aux(input logic [31:0] set_m,
            input logic [31:0] clr_m);
        logic [34:0] ans;
        logic [31:0] v;
        move(1'b0, AUX_A, 32'h0000_0000, ans);
        v = (ans[31:0] & ~clr_m) | set_m;
        if (!SLV_OPT) begin
            // Slaves without support must never see these modes
            v[AUX_ZERO_BIT] = 1'b0;
            v[AUX_L2PF_BIT] = 1'b0;
        end
        move(1'b1, AUX_A, v, ans);
    endtask : rmw_aux

endmodule : sac_pipe_model
`default_nettype wire

// File: sim/test_system_aux_control_regs.sv
/*
 * Self-checking bench for the control register bank, two cores with
 * parity, beside a single-core copy without parity on the same moves.
 * Assumes the pipeline model in sac_pipe_model drives all requests.
 */
`timescale 1ns/1ps
`default_nettype none
module test_system_aux_control_regs;
    import sac_pkg::*;

    typedef struct packed {
        logic wr;
        logic [17:0] addr;
        logic [3:0] mode;
        logic [31:0] wd;
        logic [33:0] exp;
    } sac_tb_row_type;

    localparam logic [17:0] SYS = {4'hf, 3'h0, 4'h1, 4'h0, 3'h0};
    localparam logic [17:0] AUX = {4'hf, 3'h0, 4'h1, 4'h0, 3'h1};
    localparam logic [17:0] BOP2 = {4'hf, 3'h0, 4'h1, 4'h0, 3'h2};
    localparam logic [17:0] BCP = {4'he, 3'h0, 4'h1, 4'h0, 3'h0};
    localparam logic [17:0] BCRM = {4'hf, 3'h0, 4'h1, 4'h1, 3'h0};
    localparam logic [17:0] BOP1 = {4'hf, 3'h1, 4'h1, 4'h0, 3'h1};
    // Mode code {privileged, nonsecure, permit, block}
    localparam logic [3:0] S = 4'h8, NS = 4'hc, NSP = 4'he;
    localparam logic [3:0] U = 4'h0, UN = 4'h4, SB = 4'h9;

    logic clk, rst_b, permit, blk, pin;
    logic valid, done, claim, undef, isc, bsend, brecv, coh, rr;
    logic [31:0] rdata, vbase, aux;
    logic isc_one, bsend_one, brecv_one, coh_one;
    logic [31:0] aux_one;
    sac_cp_req_type req;
    sac_cpu_state_type cpu;
    sac_sys_bank_type view;
    int fail_count, checked;
    sac_tb_row_type rows[$];
    logic [34:0] ans;

    sac_ctrl_regs #(.NUM_CORES(2), .PARITY_IMPL(1'b1)) dut (
        .i_clk(clk), .i_rst_b(rst_b), .i_cp_valid(valid), .i_cp_req(req),
        .i_cpu(cpu), .i_nonsecure_coherency_permit(permit),
        .i_secure_coproc_write_block(blk),
        .i_high_vector_reset_input(pin), .o_cp_done(done),
        .o_cp_claim(claim), .o_cp_undef(undef), .o_cp_rdata(rdata),
        .o_sys_view(view), .o_rr_replace(rr), .o_vector_base(vbase),
        .o_aux_ctrl(aux), .o_inner_shared_cacheable(isc),
        .o_bcast_send_en(bsend), .o_bcast_recv_en(brecv),
        .o_coherent_req_en(coh));

    // Single core, no parity: absent fields must read zero
    sac_ctrl_regs #(.NUM_CORES(1), .PARITY_IMPL(1'b0)) dut_one (
        .i_clk(clk), .i_rst_b(rst_b), .i_cp_valid(valid), .i_cp_req(req),
        .i_cpu(cpu), .i_nonsecure_coherency_permit(permit),
        .i_secure_coproc_write_block(blk),
        .i_high_vector_reset_input(pin), .o_cp_done(), .o_cp_claim(),
        .o_cp_undef(), .o_cp_rdata(), .o_sys_view(), .o_rr_replace(),
        .o_vector_base(), .o_aux_ctrl(aux_one),
        .o_inner_shared_cacheable(isc_one), .o_bcast_send_en(bsend_one),
        .o_bcast_recv_en(brecv_one), .o_coherent_req_en(coh_one));

    sac_pipe_model #(.SLV_OPT(1'b1)) pipe (
        .i_clk(clk), .o_req(req), .o_valid(valid), .o_cpu(cpu),
        .i_done(done), .i_claim(claim), .i_undef(undef), .i_rdata(rdata));

    always #5 clk = ~clk;

    // ==========================================================
    // Checking and closing
    task automatic check(input string what, input logic [34:0] seen,
            input logic [34:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic end_sim;
        if (fail_count == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_sim

    function automatic sac_tb_row_type r(logic wr, logic [17:0] a,
            logic [3:0] m, logic [31:0] wd, logic [1:0] cu, logic [31:0] rd);
        return {wr, a, m, wd, cu, rd};
    endfunction : r

    task automatic start_up;
        rst_b <= 1'b0;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
    endtask : start_up

    // Hang guard, far beyond the roughly 150 cycles the run needs
    initial begin
        #200000;
        fail_count++;
        end_sim();
    end

    // ==========================================================
    // Main sequence
    initial begin
        clk = 1'b0;
        rst_b = 1'b0;
        permit = 1'b0;
        blk = 1'b0;
        pin = 1'b1;
        fail_count = 0;
        checked = 0;
        rows.push_back(r(0, SYS, S, 0, 2'b10, 32'h2000));
        rows.push_back(r(0, AUX, S, 0, 2'b10, 0));
        rows.push_back(r(1, SYS, S, 32'h6007, 2'b10, 0));
        rows.push_back(r(0, SYS, S, 0, 2'b10, 32'h6007));
        rows.push_back(r(1, SYS, NS, 32'h5, 2'b10, 0));
        rows.push_back(r(0, SYS, NS, 0, 2'b10, 32'h4005));
        rows.push_back(r(0, SYS, S, 0, 2'b10, 32'h6007));
        rows.push_back(r(1, SYS, S, 32'hffff9ff8, 2'b10, 0));
        rows.push_back(r(0, SYS, S, 0, 2'b10, 0));
        rows.push_back(r(0, SYS, U, 0, 2'b11, 0));
        rows.push_back(r(1, SYS, UN, 32'h7, 2'b11, 0));
        rows.push_back(r(0, SYS, NS, 0, 2'b10, 32'h5));
        rows.push_back(r(0, AUX, U, 0, 2'b11, 0));
        rows.push_back(r(1, AUX, S, 32'hffffffff, 2'b10, 0));
        rows.push_back(r(0, AUX, S, 0, 2'b10, 32'h3cf));
        rows.push_back(r(1, AUX, NS, 0, 2'b10, 0));
        rows.push_back(r(0, AUX, NS, 0, 2'b10, 32'h3cf));
        rows.push_back(r(1, AUX, NSP, 0, 2'b10, 0));
        rows.push_back(r(0, AUX, S, 0, 2'b10, 32'h38f));
        rows.push_back(r(1, AUX, SB, 0, 2'b11, 0));
        rows.push_back(r(1, SYS, SB, 32'h7, 2'b11, 0));
        rows.push_back(r(0, AUX, SB, 0, 2'b10, 32'h38f));
        rows.push_back(r(0, SYS, SB, 0, 2'b10, 0));
        rows.push_back(r(1, AUX, S, 32'h40, 2'b10, 0));
        rows.push_back(r(0, AUX, S, 0, 2'b10, 32'h40));
        rows.push_back(r(0, BOP2, S, 0, 2'b00, 0));
        rows.push_back(r(1, BCP, S, 32'hffffffff, 2'b00, 0));
        rows.push_back(r(1, BCRM, S, 32'hffffffff, 2'b00, 0));
        rows.push_back(r(1, BOP1, S, 32'hffffffff, 2'b00, 0));
        rows.push_back(r(0, SYS, S, 0, 2'b10, 0));
        rows.push_back(r(0, AUX, S, 0, 2'b10, 32'h40));
        start_up();
        foreach (rows[i]) begin
            if (rows[i].mode[0] !== blk) begin
                // Block pin is synchronised, give it time to land
                blk <= rows[i].mode[0];
                repeat (4) @(posedge clk);
            end
            permit <= rows[i].mode[1];
            pipe.set_state(rows[i].mode[3], rows[i].mode[2]);
            pipe.move(rows[i].wr, rows[i].addr, rows[i].wd, ans);
            check("row answer", ans, {1'b1, rows[i].exp});
        end
        // ======================================================
        // Derived control lines
        pipe.rmw_aux(32'h1, 32'h0);
        check("aux", aux, 32'h41);
        check("ctl", {isc, bsend, brecv, coh}, 4'hf);
        check("one aux", aux_one, 32'h40);
        check("one ctl", {isc_one, bsend_one, brecv_one, coh_one}, 4'h8);
        pipe.rmw_aux(32'h0, 32'h40);
        check("ctl", {isc, bsend, brecv, coh}, 4'h0);
        pipe.rmw_aux(32'ha, 32'h0);
        check("aux", aux, 32'hb);
        check("one aux", aux_one, 32'ha);
        pipe.rmw_aux(32'h200, 32'h0);
        check("aux", aux, 32'h20b);
        check("one aux", aux_one, 32'ha);
        pipe.move(1'b1, SYS, 32'h6007, ans);
        check("view", {view, rr}, 5'h1f);
        check("vbase", vbase, 32'hffff0000);
        pipe.set_state(1'b1, 1'b1);
        #1;
        check("view", {view, rr}, 5'h0b);
        check("vbase", vbase, 32'h0);
        // ======================================================
        // Second reset with the vector pin low
        pin <= 1'b0;
        @(posedge clk);
        rst_b <= 1'b0;
        @(posedge clk);
        #1;
        check("reset", {done, aux}, 33'h0);
        check("reset view", view, 4'h0);
        check("reset one", aux_one, 32'h0);
        start_up();
        pipe.set_state(1'b1, 1'b0);
        pipe.move(1'b0, SYS, 32'h0, ans);
        check("strap", ans, {3'b110, 32'h0});
        end_sim();
    end

endmodule : test_system_aux_control_regs
`default_nettype wire
